// file: host_port_pkg.sv
// Constants and types shared by the byte-wide host port design.
package host_port_pkg;

	// ****************************************
	// Register offsets in the slave core space
	// ****************************************
	localparam logic [15:0] OFS_IRQ_MASK_LOW = 16'h0008;
	localparam logic [15:0] OFS_IRQ_PENDING_LOW = 16'h0009;
	localparam logic [15:0] OFS_IRQ_PENDING_HIGH = 16'h0012;
	localparam logic [15:0] OFS_IRQ_MASK_HIGH = 16'h0013;
	localparam logic [15:0] OFS_HOST_STATUS = 16'h1ff8;
	localparam logic [15:0] OFS_HOST_COMMAND = 16'h1ffa;
	localparam logic [15:0] OFS_HOST_PORT_CONTROL = 16'h1ffb;
	localparam logic [15:0] OFS_OUTBOUND_DATA = 16'h1ffc;
	localparam logic [15:0] OFS_INBOUND_DATA = 16'h1ffe;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_OUT_BUF_EMPTY_IRQ = 6;
	localparam int BIT_IN_BUF_FULL_IRQ = 7;
	localparam int BIT_CMD_BUF_FULL_IRQ = 0;
	localparam int BIT_HOST_BUS_BIT1 = 1;
	// Control register fields.
	localparam int CTL_PORT_ENABLE = 0;
	localparam int CTL_SHARED_MODE = 1;
	localparam int CTL_DEMUX_BUS = 2;
	localparam int CTL_IRQ_ON_IBE = 3;
	localparam int CTL_IRQ_ON_OBF = 4;
	// Status register fields.
	localparam int STAT_OUT_BUF_FULL = 0;
	localparam int STAT_IN_BUF_EMPTY = 1;
	localparam int STAT_CMD_BUF_FULL = 2;
	localparam int STAT_FIFO_FULL = 3;

	// ****************************************
	// Reset values and sizes
	// ****************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int BUS_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_WRITE = 4'b0010,
		PH_READ = 4'b0100,
		PH_STALL = 4'b1000
	} phase_t;

	// Host strobes travel together: latch enable, select, write, read.
	typedef struct packed {
		logic ale;
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} host_ctl_t;

	// One register access from the slave core.
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} core_req_t;

endpackage

// file: host_port.sv
// Host port datapath buffer and the byte-wide host port top module.
`timescale 1ns/1ps

// ****************************************
// Inbound data buffer
// ****************************************
module host_port_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	localparam logic [AW-1:0] IDX_ZERO = '0;
	localparam logic [AW-1:0] IDX_ONE = AW'(1);
	localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_idx;
		logic [AW-1:0] rd_idx;
		logic [AW:0] count;
	} fifo_state_t;

	fifo_state_t st_r;
	fifo_state_t st_nxt;
	logic push;
	logic pop;

	// Wraps an index at the depth, which need not be a power of two.
	function automatic logic [AW-1:0] step(input logic [AW-1:0] idx);
		step = (idx == LAST_IDX) ? IDX_ZERO : idx + IDX_ONE;
	endfunction

	// Full and empty come straight from the count so they never lie.
	assign in_ready_out = (st_r.count != DEPTH_CNT);
	assign out_valid_out = (st_r.count != '0);
	assign out_data_out = st_r.mem[st_r.rd_idx];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	// Next state of storage, pointers and count.
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr_idx] = in_data_in;
			st_nxt.wr_idx = step(st_r.wr_idx);
		end
		if (pop) begin
			st_nxt.rd_idx = step(st_r.rd_idx);
		end
		if (push && !pop) begin
			st_nxt.count = st_r.count + CNT_ONE;
		end else if (pop && !push) begin
			st_nxt.count = st_r.count - CNT_ONE;
		end
	end

	// State register.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ****************************************
// Host port top
// ****************************************
module host_port #(
	parameter int BUS_W = host_port_pkg::BUS_WIDTH,
	parameter int DEPTH = host_port_pkg::FIFO_DEPTH
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [BUS_W-1:0] host_bus_in,
	output logic [BUS_W-1:0] host_bus_out,
	output logic host_bus_oe_out,
	input wire logic host_addr_latch_en_in,
	input wire logic host_chip_sel_n_in,
	input wire logic host_write_n_in,
	input wire logic host_read_n_in,
	output logic host_irq_out,
	output logic host_irq_oe_out,
	output logic control_port_low_oe_out,
	output logic host_in_ready_out,
	input wire logic [15:0] core_addr_in,
	input wire logic core_wr_in,
	input wire logic core_rd_in,
	input wire logic [7:0] core_wdata_in,
	output logic [7:0] core_rdata_out
);
	typedef struct packed {
		logic [BUS_W-1:0] bus_s1;
		logic [BUS_W-1:0] bus_s2;
		host_port_pkg::host_ctl_t ctl_s1;
		host_port_pkg::host_ctl_t ctl_s2;
		host_port_pkg::host_ctl_t ctl_d;
		logic sel_latched;
		logic sel_taken;
		host_port_pkg::phase_t phase;
		logic [BUS_W-1:0] wr_data;
		logic [BUS_W-1:0] rd_data;
		logic bus_oe;
		logic [7:0] irq_mask_low;
		logic [7:0] irq_mask_high;
		logic [7:0] irq_pending_low;
		logic [7:0] irq_pending_high;
		logic [7:0] host_command;
		logic [7:0] host_port_control;
		logic [7:0] outbound_data;
		logic out_buf_full;
		logic cmd_buf_full;
		logic [7:0] core_rdata;
	} port_state_t;

	port_state_t st_r;
	port_state_t st_nxt;
	host_port_pkg::host_ctl_t ctl_pins;
	host_port_pkg::core_req_t core_req;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [BUS_W-1:0] fifo_head;
	logic port_en;
	logic demux;
	logic reg_sel;
	logic access_ok;
	logic data_commit;
	logic cmd_land;
	logic [7:0] status;

	// Rising and falling edges of a synchronised strobe.
	function automatic logic rose(input logic prev, input logic cur);
		rose = !prev && cur;
	endfunction

	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction

	// Core register hit test, used by both read and write decoding.
	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction

	assign ctl_pins = '{ale: host_addr_latch_en_in,
		cs_n: host_chip_sel_n_in,
		wr_n: host_write_n_in,
		rd_n: host_read_n_in};
	assign core_req = '{addr: core_addr_in, wr: core_wr_in,
		rd: core_rd_in, wdata: core_wdata_in};

	// Mode decode; shared memory mode forces the multiplexed bus.
	assign port_en = st_r.host_port_control[host_port_pkg::CTL_PORT_ENABLE];
	assign demux = st_r.host_port_control[host_port_pkg::CTL_DEMUX_BUS] &
		~st_r.host_port_control[host_port_pkg::CTL_SHARED_MODE];
	assign reg_sel = demux ? st_r.ctl_s2.ale : st_r.sel_latched;
	assign access_ok = port_en & ~st_r.ctl_s2.cs_n;

	// Inbound buffer empty is simply the buffer having nothing to give.
	assign status = {4'h0, ~fifo_in_ready, st_r.cmd_buf_full,
		~fifo_out_valid, st_r.out_buf_full};

	// A master data write waits in the stall phase until there is room.
	assign data_commit = (st_r.phase == host_port_pkg::PH_STALL) ||
		((st_r.phase == host_port_pkg::PH_WRITE) &&
		rose(st_r.ctl_d.wr_n, st_r.ctl_s2.wr_n) && !st_r.sel_taken);
	assign cmd_land = (st_r.phase == host_port_pkg::PH_WRITE) &&
		rose(st_r.ctl_d.wr_n, st_r.ctl_s2.wr_n) && st_r.sel_taken;
	assign fifo_in_valid = data_commit;
	assign fifo_pop = core_req.rd &&
		hit(core_req.addr, host_port_pkg::OFS_INBOUND_DATA);

	host_port_fifo #(
		.WIDTH(BUS_W),
		.DEPTH(DEPTH)
	) inbound_fifo (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(fifo_in_ready),
		.in_data_in(st_r.wr_data),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_head)
	);

	// Pin side outputs; the interrupt pin and control inputs follow enable.
	assign host_bus_out = st_r.rd_data;
	assign host_bus_oe_out = st_r.bus_oe;
	assign host_irq_oe_out = port_en;
	assign control_port_low_oe_out = ~port_en;
	assign host_in_ready_out = fifo_in_ready;
	assign core_rdata_out = st_r.core_rdata;
	// Interrupt is high while the port is enabled and a gated buffer flag is set.
	assign host_irq_out = port_en &
		((~fifo_out_valid &
		st_r.host_port_control[host_port_pkg::CTL_IRQ_ON_IBE]) |
		(st_r.out_buf_full &
		st_r.host_port_control[host_port_pkg::CTL_IRQ_ON_OBF]));

	// Next state: synchronisers, host phase machine, core registers.
	always_comb begin
		st_nxt = st_r;
		// Two stages before anything looks at a pin.
		st_nxt.bus_s1 = host_bus_in;
		st_nxt.bus_s2 = st_r.bus_s1;
		st_nxt.ctl_s1 = ctl_pins;
		st_nxt.ctl_s2 = st_r.ctl_s1;
		st_nxt.ctl_d = st_r.ctl_s2;

		// Multiplexed bus: address latch enable captures bit one.
		if (!demux && st_r.ctl_s2.ale) begin
			st_nxt.sel_latched =
				st_r.bus_s2[host_port_pkg::BIT_HOST_BUS_BIT1];
		end

		// Host access sequencing, one update per strobe edge.
		case (st_r.phase)
			host_port_pkg::PH_IDLE: begin
				st_nxt.bus_oe = 1'b0;
				if (access_ok && fell(st_r.ctl_d.wr_n, st_r.ctl_s2.wr_n)) begin
					st_nxt.phase = host_port_pkg::PH_WRITE;
					st_nxt.sel_taken = reg_sel;
					st_nxt.wr_data = st_r.bus_s2;
				end else if (access_ok &&
					fell(st_r.ctl_d.rd_n, st_r.ctl_s2.rd_n)) begin
					// Select low reads outbound data, high reads status.
					st_nxt.phase = host_port_pkg::PH_READ;
					st_nxt.sel_taken = reg_sel;
					st_nxt.rd_data = reg_sel ? status : st_r.outbound_data;
					st_nxt.bus_oe = 1'b1;
				end
			end
			host_port_pkg::PH_WRITE: begin
				// Track the bus while both strobes stay low.
				if (!st_r.ctl_s2.wr_n && !st_r.ctl_s2.cs_n) begin
					st_nxt.wr_data = st_r.bus_s2;
				end
				if (rose(st_r.ctl_d.wr_n, st_r.ctl_s2.wr_n)) begin
					if (st_r.sel_taken) begin
						// Writes at the status select land here too.
						st_nxt.host_command = st_r.wr_data;
						st_nxt.cmd_buf_full = 1'b1;
						st_nxt.irq_pending_high[host_port_pkg::BIT_CMD_BUF_FULL_IRQ] =
							1'b1;
						st_nxt.phase = host_port_pkg::PH_IDLE;
					end else if (fifo_in_ready) begin
						// Writes at the outbound select go inbound.
						st_nxt.irq_pending_low[host_port_pkg::BIT_OUT_BUF_EMPTY_IRQ] =
							1'b1;
						st_nxt.phase = host_port_pkg::PH_IDLE;
					end else begin
						st_nxt.phase = host_port_pkg::PH_STALL;
					end
				end
			end
			host_port_pkg::PH_STALL: begin
				// The push above is held until the core drains a byte.
				if (fifo_in_ready) begin
					st_nxt.irq_pending_low[host_port_pkg::BIT_OUT_BUF_EMPTY_IRQ] =
						1'b1;
					st_nxt.phase = host_port_pkg::PH_IDLE;
				end
			end
			host_port_pkg::PH_READ: begin
				if (st_r.ctl_s2.rd_n || st_r.ctl_s2.cs_n) begin
					st_nxt.bus_oe = 1'b0;
					st_nxt.phase = host_port_pkg::PH_IDLE;
					if (!st_r.sel_taken) begin
						st_nxt.out_buf_full = 1'b0;
						st_nxt.irq_pending_low[host_port_pkg::BIT_IN_BUF_FULL_IRQ] =
							1'b1;
					end
				end
			end
			default: begin
				st_nxt.phase = host_port_pkg::PH_IDLE;
				st_nxt.bus_oe = 1'b0;
			end
		endcase

		// Core register writes; hardware sets above win over clears.
		if (core_req.wr) begin
			if (hit(core_req.addr, host_port_pkg::OFS_IRQ_MASK_LOW)) begin
				st_nxt.irq_mask_low = core_req.wdata;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_MASK_HIGH)) begin
				st_nxt.irq_mask_high = core_req.wdata;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_PENDING_LOW)) begin
				st_nxt.irq_pending_low = core_req.wdata |
					(st_nxt.irq_pending_low & ~st_r.irq_pending_low);
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_PENDING_HIGH)) begin
				st_nxt.irq_pending_high = core_req.wdata |
					(st_nxt.irq_pending_high & ~st_r.irq_pending_high);
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_HOST_COMMAND)) begin
				if (!cmd_land) begin
					st_nxt.host_command = core_req.wdata;
				end
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_HOST_PORT_CONTROL)) begin
				st_nxt.host_port_control = core_req.wdata;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_OUTBOUND_DATA)) begin
				st_nxt.outbound_data = core_req.wdata;
				st_nxt.out_buf_full = 1'b1;
			end
		end

		// Core reads answer one cycle later; unmapped reads give zero.
		st_nxt.core_rdata = host_port_pkg::RST_BYTE;
		if (core_req.rd) begin
			if (hit(core_req.addr, host_port_pkg::OFS_IRQ_MASK_LOW)) begin
				st_nxt.core_rdata = st_r.irq_mask_low;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_MASK_HIGH)) begin
				st_nxt.core_rdata = st_r.irq_mask_high;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_PENDING_LOW)) begin
				st_nxt.core_rdata = st_r.irq_pending_low;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_IRQ_PENDING_HIGH)) begin
				st_nxt.core_rdata = st_r.irq_pending_high;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_HOST_STATUS)) begin
				st_nxt.core_rdata = status;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_HOST_COMMAND)) begin
				st_nxt.core_rdata = st_r.host_command;
				// Reading the command frees it unless a new one lands now.
				if (!cmd_land) begin
					st_nxt.cmd_buf_full = 1'b0;
				end
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_HOST_PORT_CONTROL)) begin
				st_nxt.core_rdata = st_r.host_port_control;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_OUTBOUND_DATA)) begin
				st_nxt.core_rdata = st_r.outbound_data;
			end else if (hit(core_req.addr,
				host_port_pkg::OFS_INBOUND_DATA)) begin
				// Popping the last byte sets the empty flag again.
				st_nxt.core_rdata = fifo_out_valid ? fifo_head :
					host_port_pkg::RST_BYTE;
			end
		end

		// Disabling the port abandons any host access in flight.
		if (!port_en) begin
			st_nxt.phase = host_port_pkg::PH_IDLE;
			st_nxt.bus_oe = 1'b0;
		end
	end

	// State register; select, write and read strobes reset to their idle high level, latch enable low.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '0;
			st_r.ctl_s1 <= '{ale: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
			st_r.ctl_s2 <= '{ale: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
			st_r.ctl_d <= '{ale: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
			st_r.phase <= host_port_pkg::PH_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// file: host_port_monitor.sv
// Concurrent checks on the pins of the byte-wide host port.
`timescale 1ns/1ps
module host_port_monitor #(
	parameter int BUS_W = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [BUS_W-1:0] host_bus_out,
	input wire logic host_bus_oe_out,
	input wire logic host_chip_sel_n_in,
	input wire logic host_write_n_in,
	input wire logic host_read_n_in,
	input wire logic host_irq_out,
	input wire logic host_irq_oe_out,
	input wire logic control_port_low_oe_out,
	input wire logic [15:0] core_addr_in,
	input wire logic core_wr_in,
	input wire logic core_rd_in,
	input wire logic [7:0] core_wdata_in,
	input wire logic [7:0] core_rdata_out
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic [7:0] ctl_r;
	logic rd_sel;
	logic ctl_wr;
	logic outb_wr;

	// Decodes kept outside the properties so they stay short.
	assign rd_sel = !host_read_n_in && !host_chip_sel_n_in;
	assign ctl_wr = core_wr_in &&
		core_addr_in == host_port_pkg::OFS_HOST_PORT_CONTROL;
	assign outb_wr = core_wr_in &&
		core_addr_in == host_port_pkg::OFS_OUTBOUND_DATA;

	// Mirror of the control byte, so irq gating can be predicted.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctl_r <= 8'h00;
		end else if (ctl_wr) begin
			ctl_r <= core_wdata_in;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);

	sequence read_start;
		$fell(host_read_n_in) && !host_chip_sel_n_in && host_irq_oe_out;
	endsequence

	sequence read_end;
		$rose(host_read_n_in);
	endsequence

	a_oe_rises: assert property (
		read_start |-> ##[2:5] host_bus_oe_out)
		else $error("read strobe not answered on the bus");
	a_oe_cause: assert property (
		$rose(host_bus_oe_out) |-> $past(rd_sel, 2))
		else $error("bus driven without a selected read");
	a_oe_drops: assert property (
		read_end |-> ##[1:6] !host_bus_oe_out)
		else $error("bus still driven after read ended");
	a_oe_holds: assert property (
		host_bus_oe_out && rd_sel |=> host_bus_oe_out)
		else $error("bus released during a read");
	a_data_steady: assert property (
		host_bus_oe_out && $past(host_bus_oe_out) |->
		$stable(host_bus_out))
		else $error("read data changed while driven");
	a_write_quiet: assert property (
		!host_write_n_in |-> !host_bus_oe_out)
		else $error("bus driven during a write strobe");
	a_rdata_idle: assert property (
		!$past(core_rd_in) |-> core_rdata_out == 8'h00)
		else $error("core read data without a read");
	a_pins_swap: assert property (
		host_irq_oe_out != control_port_low_oe_out &&
		control_port_low_oe_out ==
		!ctl_r[host_port_pkg::CTL_PORT_ENABLE])
		else $error("control pins do not follow port enable");
	a_enable_follows: assert property (
		ctl_wr |=> host_irq_oe_out ==
		ctl_r[host_port_pkg::CTL_PORT_ENABLE])
		else $error("port enable does not follow control");
	a_irq_on_full: assert property (
		outb_wr && ctl_r[host_port_pkg::CTL_PORT_ENABLE] &&
		ctl_r[host_port_pkg::CTL_IRQ_ON_OBF] |=> host_irq_out)
		else $error("irq not raised by outbound write");
endmodule

// file: host_master_model.sv
// Behavioural master processor driving the host port strobes and bus.
`timescale 1ns/1ps
module host_master_model (
	input wire logic mclk_in,
	input wire logic [7:0] dev_bus_in,
	input wire logic dev_oe_in,
	output logic [7:0] bus_out,
	output logic ale_out,
	output logic cs_n_out,
	output logic wr_n_out,
	output logic rd_n_out
);
	logic [7:0] drv;
	logic drv_en;
	logic [7:0] last;

	// Wire level: a released bus flips every cycle, so stale data never
	// passes for a valid read.
	assign bus_out = dev_oe_in ? dev_bus_in : (drv_en ? drv : ~last);

	// Remember the wire so the released pattern keeps changing.
	always @(posedge mclk_in) begin
		last <= bus_out;
	end

	// Idle master: select, write and read strobes high, latch enable low, bus released.
	initial begin
		drv = 8'h00;
		drv_en = 1'b0;
		last = 8'h00;
		ale_out = 1'b0;
		cs_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// One access; len sets how long the strobe stays low (3 at least).
	task automatic access(input logic wr, input logic sel, input logic mux,
		input logic cs_n, input int len, input logic [7:0] wdata,
		output logic [7:0] rdata);
		step(1);
		if (mux) begin
			drv = sel ? 8'h02 : 8'h00;
			drv_en = 1'b1;
			ale_out = 1'b1;
			step(3);
			ale_out = 1'b0;
		end else begin
			ale_out = sel;
		end
		cs_n_out = cs_n;
		drv = wdata;
		drv_en = wr;
		step(1);
		wr_n_out = !wr;
		rd_n_out = wr;
		step(len);
		rdata = bus_out;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		step(3);
		drv_en = 1'b0;
		cs_n_out = 1'b1;
		ale_out = 1'b0;
		step(4);
	endtask
endmodule

// file: host_port_test.sv
// Self-checking testbench for the byte-wide host port.
`timescale 1ns/1ps
module host_port_test;
	localparam logic [15:0] A_CTL = host_port_pkg::OFS_HOST_PORT_CONTROL;
	localparam logic [15:0] A_STAT = host_port_pkg::OFS_HOST_STATUS;
	localparam logic [15:0] A_INB = host_port_pkg::OFS_INBOUND_DATA;
	localparam logic [15:0] A_OUTB = host_port_pkg::OFS_OUTBOUND_DATA;
	localparam logic [15:0] A_PL = host_port_pkg::OFS_IRQ_PENDING_LOW;
	localparam logic [15:0] A_CMD = host_port_pkg::OFS_HOST_COMMAND;
	logic mclk_in, rstn_in, host_bus_oe_out, host_addr_latch_en_in;
	logic host_chip_sel_n_in, host_write_n_in, host_read_n_in;
	logic host_irq_out, host_irq_oe_out, control_port_low_oe_out;
	logic host_in_ready_out, core_wr_in, core_rd_in;
	logic [7:0] host_bus_in, host_bus_out, core_wdata_in, core_rdata_out;
	logic [7:0] rb;
	logic [15:0] core_addr_in;
	int mismatches, compares;

	host_port host_port_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
		.host_bus_oe_out(host_bus_oe_out),
		.host_addr_latch_en_in(host_addr_latch_en_in),
		.host_chip_sel_n_in(host_chip_sel_n_in),
		.host_write_n_in(host_write_n_in), .host_read_n_in(host_read_n_in),
		.host_irq_out(host_irq_out), .host_irq_oe_out(host_irq_oe_out),
		.control_port_low_oe_out(control_port_low_oe_out),
		.host_in_ready_out(host_in_ready_out), .core_addr_in(core_addr_in),
		.core_wr_in(core_wr_in), .core_rd_in(core_rd_in),
		.core_wdata_in(core_wdata_in), .core_rdata_out(core_rdata_out));

	host_master_model host_master_model_inst (.mclk_in(mclk_in),
		.dev_bus_in(host_bus_out), .dev_oe_in(host_bus_oe_out),
		.bus_out(host_bus_in), .ale_out(host_addr_latch_en_in),
		.cs_n_out(host_chip_sel_n_in), .wr_n_out(host_write_n_in),
		.rd_n_out(host_read_n_in));

	// 100 MHz clock.
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Pin snapshot: oe, irq, irq_oe, control_oe, in_ready, then zeros.
	function automatic logic [7:0] pins();
		return {host_bus_oe_out, host_irq_out, host_irq_oe_out,
			control_port_low_oe_out, host_in_ready_out, 3'b000};
	endfunction

	task automatic cwr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		#1;
		core_addr_in = a;
		core_wdata_in = d;
		core_wr_in = 1'b1;
		@(posedge mclk_in);
		#1;
		core_wr_in = 1'b0;
	endtask

	task automatic crd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		#1;
		core_addr_in = a;
		core_rd_in = 1'b1;
		@(posedge mclk_in);
		#1;
		core_rd_in = 1'b0;
		check(core_rdata_out, exp);
	endtask

	task automatic hw(input logic sel, input logic mux, input logic [7:0] d);
		host_master_model_inst.access(1'b1, sel, mux, 1'b0, 5, d, rb);
	endtask

	task automatic hr(input logic sel, input logic mux, input int len,
		input logic [7:0] exp);
		host_master_model_inst.access(1'b0, sel, mux, 1'b0, len, 8'h00, rb);
		check(rb, exp);
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard: a run that overstays its budget counts as a failure.
	initial begin
		repeat (20000) @(posedge mclk_in);
		mismatches++;
		$display("ERROR %0t run did not finish", $time);
		final_report();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		mismatches = 0;
		compares = 0;
		core_addr_in = 16'h0000;
		core_wdata_in = 8'h00;
		core_wr_in = 1'b0;
		core_rd_in = 1'b0;
		rstn_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		rstn_in = 1'b1;
		check(pins(), 8'h18);
		crd(16'h0100, 8'h00);
		crd(A_STAT, 8'h02);
		cwr(A_CTL, 8'h15);
		check(pins(), 8'h28);
		crd(A_CTL, 8'h15);
		cwr(host_port_pkg::OFS_IRQ_MASK_LOW, 8'hc0);
		crd(host_port_pkg::OFS_IRQ_MASK_LOW, 8'hc0);
		cwr(host_port_pkg::OFS_IRQ_MASK_HIGH, 8'h01);
		crd(host_port_pkg::OFS_IRQ_MASK_HIGH, 8'h01);
		cwr(A_OUTB, 8'ha5);
		check(pins(), 8'h68);
		crd(A_STAT, 8'h03);
		hr(1'b0, 1'b0, 9, 8'ha5);
		check(pins(), 8'h28);
		crd(A_STAT, 8'h02);
		crd(A_PL, 8'h80);
		hr(1'b1, 1'b0, 5, 8'h02);
		cwr(A_PL, 8'h00);
		cwr(A_CTL, 8'h0d);
		check(pins(), 8'h68);
		hw(1'b0, 1'b0, 8'h3c);
		check(pins(), 8'h28);
		crd(A_PL, 8'h40);
		crd(A_STAT, 8'h00);
		crd(A_INB, 8'h3c);
		check(pins(), 8'h68);
		hw(1'b1, 1'b0, 8'h5a);
		crd(host_port_pkg::OFS_IRQ_PENDING_HIGH, 8'h01);
		crd(A_STAT, 8'h06);
		crd(A_CMD, 8'h5a);
		crd(A_STAT, 8'h02);
		cwr(A_PL, 8'h00);
		host_master_model_inst.access(1'b1, 1'b0, 1'b0, 1'b1, 5,
			8'h99, rb);
		crd(A_PL, 8'h00);
		crd(A_STAT, 8'h02);
		cwr(A_CTL, 8'h09);
		hw(1'b1, 1'b1, 8'h77);
		hr(1'b1, 1'b1, 5, 8'h06);
		crd(A_CMD, 8'h77);
		cwr(A_CTL, 8'h0f);
		hw(1'b0, 1'b1, 8'h11);
		crd(A_STAT, 8'h00);
		crd(A_INB, 8'h11);
		cwr(A_CTL, 8'h0d);
		for (int i = 0; i < 8; i++) begin
			hw(1'b0, 1'b0, 8'h80 + 8'(i));
		end
		// A ninth byte finds the buffer full and must wait, not vanish.
		hw(1'b0, 1'b0, 8'h88);
		check(pins(), 8'h20);
		crd(A_STAT, 8'h08);
		for (int i = 0; i < 8; i++) begin
			crd(A_INB, 8'h80 + 8'(i));
		end
		crd(A_INB, 8'h88);
		check(pins(), 8'h68);
		cwr(A_STAT, 8'hff);
		crd(A_STAT, 8'h02);
		cwr(A_INB, 8'hff);
		crd(A_INB, 8'h00);
		cwr(A_PL, 8'h00);
		cwr(A_CTL, 8'h00);
		check(pins(), 8'h18);
		hw(1'b0, 1'b0, 8'h44);
		crd(A_PL, 8'h00);
		crd(A_STAT, 8'h02);
		final_report();
	end
endmodule

bind host_port host_port_monitor #(.BUS_W(BUS_W), .DEPTH(DEPTH))
	host_port_monitor_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.host_bus_out(host_bus_out), .host_bus_oe_out(host_bus_oe_out),
	.host_chip_sel_n_in(host_chip_sel_n_in),
	.host_write_n_in(host_write_n_in), .host_read_n_in(host_read_n_in),
	.host_irq_out(host_irq_out), .host_irq_oe_out(host_irq_oe_out),
	.control_port_low_oe_out(control_port_low_oe_out),
	.core_addr_in(core_addr_in), .core_wr_in(core_wr_in),
	.core_rd_in(core_rd_in), .core_wdata_in(core_wdata_in),
	.core_rdata_out(core_rdata_out));
